// File: bench/eye_monitor_sva.sv
// port assertions for the eye monitor register block
`timescale 1ns/1ps
`default_nettype none
module eye_monitor_sva #(
  parameter int OP_CYCLES = 4
)(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [6:0]  mgmt_address,
  input wire logic        mgmt_write,
  input wire logic        mgmt_read,
  input wire logic [31:0] mgmt_writedata,
  input wire logic [31:0] mgmt_readdata,
  input wire logic [9:0]  phys_channel,
  input wire logic        monitor_on,
  input wire logic [5:0]  phase_step,
  input wire logic [5:0]  height_level,
  input wire logic        height_positive
);
  // busy shadow runs one cycle long so both busy readings stay legal
  logic [7:0]  cnt;
  logic [7:0]  next_cnt;
  logic        trig;
  logic        wchan;
  logic [13:0] mir;
  assign trig  = mgmt_write && mgmt_address == 7'h12 &&
                 |mgmt_writedata[1:0] && cnt == 8'h00;
  assign wchan = mgmt_write && mgmt_address == 7'h10 && cnt == 8'h00;
  assign mir   = {monitor_on, phase_step, height_level, height_positive};
  always_comb
  begin
    next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    if (trig)
      next_cnt = 8'(OP_CYCLES + 2);
  end
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      cnt <= 8'h00;
    else
      cnt <= next_cnt;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_chan_follow: assert property (
    !$stable(phys_channel) |-> $past(wchan) || $past(wchan, 2))
    else $error("channel output moved without a channel write");
  chk_busy_idle: assert property (
    mgmt_read && mgmt_address == 7'h12 && cnt == 8'h00
    |=> !mgmt_readdata[8]) else $error("busy seen with no operation");
  chk_mirror_late: assert property (
    !$stable(mir) |-> $past(cnt) == 8'h01)
    else $error("eye settings moved outside an operation end");
  chk_hold_busy: assert property (
    trig |=> $stable(mir)[*4]) else $error("settings moved early");
  chk_pol_forced: assert property (
    $rose(monitor_on) |-> height_positive)
    else $error("monitor enable left polarity negative");
  chk_rd_hold: assert property (
    !mgmt_read |=> $stable(mgmt_readdata))
    else $error("read data moved without a read");
  chk_chan_width: assert property (
    mgmt_read && mgmt_address == 7'h10 |-> ##1 mgmt_readdata[31:10] == 0)
    else $error("channel register wider than ten bits");
  chk_offset_width: assert property (
    mgmt_read && mgmt_address == 7'h13 |-> ##1 mgmt_readdata[31:6] == 0)
    else $error("offset register wider than six bits");
  chk_data_width: assert property (
    mgmt_read && mgmt_address == 7'h14 |=> mgmt_readdata[31:16] == 0)
    else $error("data register wider than sixteen bits");
  cover property (trig && mgmt_writedata[1]);
  cover property (trig && mgmt_writedata[0]);
  cover property ($rose(monitor_on));
endmodule
bind eye_monitor_ber_registers eye_monitor_sva #(.OP_CYCLES(OP_CYCLES)) u_sva (
  .ref_clk(ref_clk), .nrst(nrst), .mgmt_address(mgmt_address),
  .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
  .mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
  .phys_channel(phys_channel), .monitor_on(monitor_on),
  .phase_step(phase_step), .height_level(height_level),
  .height_positive(height_positive));
`default_nettype wire

// File: bench/sample_source.sv
// stand-in for the eye and recovered sample paths of one channel
`timescale 1ns/1ps
`default_nettype none
module sample_source (
  input  wire logic ref_clk,
  input  wire logic inject,
  output var  logic sample_eye,
  output var  logic sample_cdr
);
  logic b;
  // random data so a stuck comparator cannot match by luck
  always @(negedge ref_clk)
  begin
    b = 1'($urandom);
    sample_cdr <= b;
    sample_eye <= b ^ inject;
  end
endmodule
`default_nettype wire

// File: bench/test_eye_monitor_ber_registers.sv
// self-checking bench for the eye monitor register block
`timescale 1ns/1ps
`default_nettype none
module test_eye_monitor_ber_registers;
  localparam int NCH = 4;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [6:0]  mgmt_address = 7'h00;
  logic        mgmt_write = 1'b0;
  logic        mgmt_read = 1'b0;
  logic [31:0] mgmt_writedata = 32'h0;
  logic [31:0] mgmt_readdata;
  logic        sample_eye;
  logic        sample_cdr;
  logic        inject = 1'b0;
  logic [9:0]  phys_channel;
  logic        monitor_on;
  logic [5:0]  phase_step;
  logic [5:0]  height_level;
  logic        height_positive;
  logic        single_axis_mode;
  logic        checker_on;
  int          miscompares = 0;
  int          check_count = 0;
  logic [31:0] v;
  logic [31:0] e1;
  logic [5:0]  ph;
  logic [5:0]  ht;
  logic [5:0]  offs [8] = '{6'h0, 6'h1, 6'h2, 6'h3, 6'h5, 6'h6, 6'h7, 6'h8};
  logic [6:0]  dirs [4] = '{7'h10, 7'h12, 7'h13, 7'h14};

  always #10 ref_clk = ~ref_clk;

  eye_monitor_ber_registers #(.NUM_CHANNELS(NCH)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .mgmt_address(mgmt_address),
    .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
    .mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
    .sample_eye(sample_eye), .sample_cdr(sample_cdr),
    .phys_channel(phys_channel), .monitor_on(monitor_on),
    .phase_step(phase_step), .height_level(height_level),
    .height_positive(height_positive), .single_axis_mode(single_axis_mode),
    .checker_on(checker_on));
  sample_source u_src (.ref_clk(ref_clk), .inject(inject),
    .sample_eye(sample_eye), .sample_cdr(sample_cdr));

  // ------------------------------
  // bus, check and result tasks
  // ------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    mgmt_address = a;
    mgmt_writedata = d;
    mgmt_write = 1'b1;
    @(negedge ref_clk);
    mgmt_write = 1'b0;
  endtask
  task rd(input logic [6:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    mgmt_address = a;
    mgmt_read = 1'b1;
    @(negedge ref_clk);
    mgmt_read = 1'b0;
    d = mgmt_readdata;
  endtask
  task idle;
    for (int i = 0; i < 20; i++)
    begin
      rd(7'h12, v);
      if (v[8] === 1'b0)
        return;
    end
    $display("[ERR] %0t busy never cleared", $time);
    miscompares++;
    end_of_test;
  endtask
  task op(input logic r, input logic [5:0] off, input logic [15:0] d,
          output logic [31:0] q);
    idle;
    wr(7'h13, {26'h0, off});
    wr(7'h14, {16'h0, d});
    wr(7'h12, {30'h0, r, !r});
    rd(7'h12, v);
    chk(v[8], 1'b1);
    idle;
    rd(7'h14, q);
  endtask

  initial
  begin
    void'($urandom(47));
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    foreach (dirs[i])
    begin
      rd(dirs[i], v);
      chk(v, 0);
    end
    foreach (offs[i])
    begin
      op(1'b1, offs[i], 16'h0, v);
      chk(v, 0);
    end
    for (int n = 0; n < 6; n++)
    begin
      ph = (n == 0) ? 6'h3F : 6'($urandom);
      ht = (n == 0) ? 6'h3F : 6'($urandom);
      idle;
      wr(7'h10, 32'(n % NCH));
      op(1'b0, 6'h1, {10'h0, ph}, v);
      op(1'b0, 6'h2, {10'h0, ht}, v);
      op(1'b1, 6'h1, 16'h0, v);
      chk(v, {26'h0, ph});
      op(1'b1, 6'h2, 16'h0, v);
      chk(v, {26'h0, ht});
      chk({phase_step, height_level}, {ph, ht});
      chk(phys_channel, 32'(n % NCH));
    end
    for (int k = 1; k >= 0; k--)
    begin
      op(1'b1, 6'h3, 16'h0, v);
      e1 = k ? 32'h4 : 32'h2000;
      op(1'b0, 6'h3, (v[15:0] & 16'hDFFB) | e1[15:0], v);
      chk({single_axis_mode, height_positive}, {!k[0], k[0]});
    end
    op(1'b0, 6'h0, 16'h0001, v);
    chk({monitor_on, height_positive, checker_on}, 3'b110);
    for (int k = 0; k < 2; k++)
    begin
      idle;
      wr(7'h10, k ? 32'h0 : 32'(NCH));
      wr(7'h13, k ? 32'h4 : 32'h0);
      wr(7'h12, 32'h1);
      idle;
      rd(7'h12, v);
      chk(v[9], 1'b1);
    end
    op(1'b1, 6'h0, 16'h0, v);
    rd(7'h12, v);
    chk(v[9], 1'b0);
    op(1'b0, 6'h0, 16'h0003, v);
    chk(checker_on, 1'b1);
    inject <= 1'b1;
    op(1'b0, 6'h0, 16'h000F, v);
    repeat (600) @(negedge ref_clk);
    op(1'b0, 6'h0, 16'h0003, v);
    op(1'b0, 6'h0, 16'h0013, v);
    op(1'b1, 6'h7, 16'h0, e1);
    op(1'b1, 6'h5, 16'h0, v);
    chk(32'(e1 >= 600), 1);
    chk(32'(v == e1 >> 8 || v == (e1 >> 8) + 1), 1);
    op(1'b1, 6'h8, 16'h0, v);
    chk(v, 0);
    repeat (300) @(negedge ref_clk);
    op(1'b0, 6'h0, 16'h0013, v);
    op(1'b1, 6'h7, 16'h0, v);
    chk(v, e1);
    op(1'b0, 6'h0, 16'h0007, v);
    op(1'b0, 6'h0, 16'h001B, v);
    op(1'b1, 6'h7, 16'h0, v);
    chk(32'(v > e1), 1);
    op(1'b0, 6'h0, 16'h000B, v);
    op(1'b1, 6'h7, 16'h0, v);
    chk(v, 0);
    op(1'b0, 6'h0, 16'h0005, v);
    repeat (300) @(negedge ref_clk);
    op(1'b0, 6'h0, 16'h0015, v);
    op(1'b1, 6'h7, 16'h0, v);
    chk(v, 0);
    nrst = 1'b0;
    @(negedge ref_clk);
    nrst = 1'b1;
    rd(7'h10, v);
    chk(v, 0);
    chk({monitor_on, phase_step, height_level, phys_channel}, 0);
    end_of_test;
  end
endmodule
`default_nettype wire

// File: common/eye_monitor_cfg.svh
// register offsets, field positions, reset values and limits of the eye monitor
`ifndef EYE_MONITOR_CFG_SVH
`define EYE_MONITOR_CFG_SVH

// direct registers (word addresses on the 7-bit management bus)
`define ADDR_CHANNEL_SELECT   7'h10
`define ADDR_OP_CONTROL       7'h12
`define ADDR_OFFSET_SELECT    7'h13
`define ADDR_INDIRECT_DATA    7'h14

// operation control/status bits
`define OPC_WRITE_BIT         0
`define OPC_READ_BIT          1
`define OPC_BUSY_BIT          8
`define OPC_ERROR_BIT         9

// indirect offsets
`define IND_CONTROL           6'h00
`define IND_HPHASE            6'h01
`define IND_VHEIGHT           6'h02
`define IND_MODE_POL          6'h03
`define IND_BITS_LO           6'h05
`define IND_BITS_HI           6'h06
`define IND_ERRS_LO           6'h07
`define IND_ERRS_HI           6'h08

// fields of indirect offset 0 and 3
`define CTL_MON_ON_BIT        0
`define CTL_RATE_ON_BIT       1
`define CTL_COUNT_ON_BIT      2
`define CTL_SNAP_LSB          3
`define MODE_POL_BIT          2
`define MODE_SINGLE_AXIS_BIT  13

// snapshot/reset codes
`define SNAP_CLEAR_ALL        2'b01
`define SNAP_TAKE             2'b10
`define SNAP_TAKE_CLEAR       2'b11

`define RESET_ZERO            16'h0000
`define BITS_PER_INCREMENT    256
`define OP_LATENCY            4

`endif

// File: common/eye_monitor_pkg.sv
// types shared by the eye monitor register block
package eye_monitor_pkg;
  typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_DONE} op_state_t;
  typedef logic [63:0] counter_t;
endpackage

// File: design/eye_monitor_ber_registers.sv
// eye monitor and bit-error-rate register block behind the management port
// Contract
// - logical channel translated to physical channel
// - error flag on invalid channel or offset
// - busy high while indirect access runs
// - read/write trigger bits start indirect access
// - six-bit indirect offset register
// - sixteen-bit indirect data register
// - all registers reset to zero
// - snapshot/reset codes clear, copy, copy-then-clear
// - counter enable accumulates, else holds values
// - rate enable gates counters and checker
// - rate controls exist only with build option
// - monitor-enable bit switches eye monitor on
// - monitor-enable write forces polarity positive
// - six-bit phase, 64 steps over 2 UI
// - six-bit height, 64 threshold levels
// - bit 13 selects single-axis mode
// - polarity bit: zero negative, one positive
// - 64-bit bit counter, one per 256 bits
// - 64-bit error counter of erroneous bits
// - checker compares eye and recovered samples
// - one shared counter set, one channel
`timescale 1ns/1ps
`include "eye_monitor_cfg.svh"
`default_nettype none

module eye_monitor_ber_registers
  import eye_monitor_pkg::*;
#(
  parameter int NUM_CHANNELS = 4,
  parameter bit RATE_BLOCK   = 1'b1,
  parameter int OP_CYCLES    = `OP_LATENCY
)(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [6:0]  mgmt_address,
  input  wire logic        mgmt_write,
  input  wire logic        mgmt_read,
  input  wire logic [31:0] mgmt_writedata,
  output var  logic [31:0] mgmt_readdata,
  input  wire logic        sample_eye,
  input  wire logic        sample_cdr,
  output var  logic [9:0]  phys_channel,
  output var  logic        monitor_on,
  output var  logic [5:0]  phase_step,
  output var  logic [5:0]  height_level,
  output var  logic        height_positive,
  output var  logic        single_axis_mode,
  output var  logic        checker_on
);

  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 1024 || OP_CYCLES < 1 ||
      OP_CYCLES > 255)
  begin
    $error("eye_monitor_ber_registers: unsupported parameters");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic offset_valid(input logic [5:0] off);
    case (off)
      `IND_CONTROL, `IND_HPHASE, `IND_VHEIGHT, `IND_MODE_POL:
        offset_valid = 1'b1;
      `IND_BITS_LO, `IND_BITS_HI, `IND_ERRS_LO, `IND_ERRS_HI:
        offset_valid = RATE_BLOCK;
      default: offset_valid = 1'b0;
    endcase
  endfunction

  function automatic logic write_hit(input logic [6:0] a, input logic [6:0] r,
                                     input logic wr);
    write_hit = wr && (a == r);
  endfunction

  // ----------------------------------------------------------------
  // direct registers and indirect operation engine
  // ----------------------------------------------------------------
  logic [9:0]  channel_select;
  logic [5:0]  indirect_offset_select;
  logic [15:0] indirect_data;
  logic        busy;
  logic        op_error;
  logic        op_is_write;
  logic [7:0]  op_count;
  op_state_t   op_state;
  logic [1:0]  ctl_low;
  logic        count_on;
  logic [1:0]  snap_code;
  logic [5:0]  hphase;
  logic [5:0]  vheight;
  logic [15:0] mode_pol;
  counter_t    bit_count;
  counter_t    err_count;
  counter_t    bit_snap;
  counter_t    err_snap;
  logic [7:0]  bit_prescale;
  logic        do_snap;
  logic        do_clear_cnt;
  logic        do_clear_snap;
  logic [9:0]  next_channel_select;
  logic [5:0]  next_indirect_offset_select;
  logic [15:0] next_indirect_data;
  logic        next_busy;
  logic        next_op_error;
  logic        next_op_is_write;
  logic [7:0]  next_op_count;
  op_state_t   next_op_state;
  logic [1:0]  next_ctl_low;
  logic        next_count_on;
  logic [1:0]  next_snap_code;
  logic [5:0]  next_hphase;
  logic [5:0]  next_vheight;
  logic [15:0] next_mode_pol;
  logic [31:0] next_mgmt_readdata;
  logic [15:0] ind_read_value;
  logic        chan_ok;

  assign chan_ok = (32'(channel_select) < 32'(NUM_CHANNELS));
  always_comb
  begin
    case (indirect_offset_select)
      `IND_CONTROL:  ind_read_value = {11'h000, snap_code, count_on, ctl_low};
      `IND_HPHASE:   ind_read_value = {10'h000, hphase};
      `IND_VHEIGHT:  ind_read_value = {10'h000, vheight};
      `IND_MODE_POL: ind_read_value = mode_pol;
      // 16-bit data port returns bits 15:0 and 47:32 of each counter word
      `IND_BITS_LO:  ind_read_value = bit_snap[15:0];
      `IND_BITS_HI:  ind_read_value = bit_snap[47:32];
      `IND_ERRS_LO:  ind_read_value = err_snap[15:0];
      `IND_ERRS_HI:  ind_read_value = err_snap[47:32];
      default:       ind_read_value = `RESET_ZERO;
    endcase
  end

  always_comb
  begin
    next_channel_select         = channel_select;
    next_indirect_offset_select = indirect_offset_select;
    next_indirect_data          = indirect_data;
    next_busy                   = busy;
    next_op_error               = op_error;
    next_op_is_write            = op_is_write;
    next_op_count               = op_count;
    next_op_state               = op_state;
    next_ctl_low                = ctl_low;
    next_count_on               = count_on;
    next_snap_code              = snap_code;
    next_hphase                 = hphase;
    next_vheight                = vheight;
    next_mode_pol               = mode_pol;
    do_snap                     = 1'b0;
    do_clear_cnt                = 1'b0;
    do_clear_snap               = 1'b0;

    // register writes are ignored while an operation runs
    if (!busy)
    begin
      if (write_hit(mgmt_address, `ADDR_CHANNEL_SELECT, mgmt_write))
        next_channel_select = mgmt_writedata[9:0];
      if (write_hit(mgmt_address, `ADDR_OFFSET_SELECT, mgmt_write))
        next_indirect_offset_select = mgmt_writedata[5:0];
      if (write_hit(mgmt_address, `ADDR_INDIRECT_DATA, mgmt_write))
        next_indirect_data = mgmt_writedata[15:0];
      if (write_hit(mgmt_address, `ADDR_OP_CONTROL, mgmt_write) &&
          (mgmt_writedata[`OPC_READ_BIT] || mgmt_writedata[`OPC_WRITE_BIT]))
      begin
        next_op_is_write = mgmt_writedata[`OPC_WRITE_BIT];
        next_op_error    = !(chan_ok && offset_valid(indirect_offset_select));
        next_busy        = 1'b1;
        next_op_count    = 8'(OP_CYCLES);
        next_op_state    = OP_RUN;
      end
    end

    case (op_state)
      OP_IDLE: next_op_state = next_op_state;
      OP_RUN:
        if (op_count > 8'h01)
          next_op_count = op_count - 8'h01;
        else
          next_op_state = OP_DONE;
      OP_DONE:
      begin
        next_op_state = OP_IDLE;
        next_busy     = 1'b0;
        if (!op_error && !op_is_write)
          next_indirect_data = ind_read_value;
        else if (!op_error)
          case (indirect_offset_select)
            `IND_CONTROL:
            begin
              next_ctl_low[0] = indirect_data[`CTL_MON_ON_BIT];
              if (indirect_data[`CTL_MON_ON_BIT])
                next_mode_pol[`MODE_POL_BIT] = 1'b1;
              if (RATE_BLOCK)
              begin
                next_ctl_low[1] = indirect_data[`CTL_RATE_ON_BIT];
                next_count_on   = indirect_data[`CTL_COUNT_ON_BIT];
                next_snap_code  = indirect_data[`CTL_SNAP_LSB +: 2];
                case (indirect_data[`CTL_SNAP_LSB +: 2])
                  `SNAP_CLEAR_ALL:
                  begin
                    do_clear_cnt  = 1'b1;
                    do_clear_snap = 1'b1;
                  end
                  `SNAP_TAKE: do_snap = 1'b1;
                  `SNAP_TAKE_CLEAR:
                  begin
                    do_snap      = 1'b1;
                    do_clear_cnt = 1'b1;
                  end
                  default: do_snap = 1'b0;
                endcase
              end
            end
            `IND_HPHASE:   next_hphase = indirect_data[5:0];
            `IND_VHEIGHT:  next_vheight = indirect_data[5:0];
            // reserved bits stored as written; host preserves them
            `IND_MODE_POL: next_mode_pol = indirect_data;
            default:       next_mode_pol = next_mode_pol;
          endcase
      end
      default: next_op_state = OP_IDLE;
    endcase
    case (mgmt_address)
      `ADDR_CHANNEL_SELECT: next_mgmt_readdata = {22'h000000, channel_select};
      `ADDR_OP_CONTROL:
        next_mgmt_readdata = {22'h000000, op_error, busy, 8'h00};
      `ADDR_OFFSET_SELECT:
        next_mgmt_readdata = {26'h0000000, indirect_offset_select};
      `ADDR_INDIRECT_DATA: next_mgmt_readdata = {16'h0000, indirect_data};
      default:             next_mgmt_readdata = 32'h00000000;
    endcase
    if (!mgmt_read)
      next_mgmt_readdata = mgmt_readdata;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      channel_select         <= 10'h000;
      indirect_offset_select <= 6'h00;
      indirect_data          <= 16'h0000;
      busy                   <= 1'b0;
      op_error               <= 1'b0;
      op_is_write            <= 1'b0;
      op_count               <= 8'h00;
      op_state               <= OP_IDLE;
      ctl_low                <= 2'b00;
      count_on               <= 1'b0;
      snap_code              <= 2'b00;
      hphase                 <= 6'h00;
      vheight                <= 6'h00;
      mode_pol               <= 16'h0000;
      mgmt_readdata          <= 32'h00000000;
    end
    else
    begin
      channel_select         <= next_channel_select;
      indirect_offset_select <= next_indirect_offset_select;
      indirect_data          <= next_indirect_data;
      busy                   <= next_busy;
      op_error               <= next_op_error;
      op_is_write            <= next_op_is_write;
      op_count               <= next_op_count;
      op_state               <= next_op_state;
      ctl_low                <= next_ctl_low;
      count_on               <= next_count_on;
      snap_code              <= next_snap_code;
      hphase                 <= next_hphase;
      vheight                <= next_vheight;
      mode_pol               <= next_mode_pol;
      mgmt_readdata          <= next_mgmt_readdata;
    end
  end

  // ----------------------------------------------------------------
  // shared bit checker and counters
  // ----------------------------------------------------------------
  // one counter set for all channels: switching channels corrupts it
  counter_t   next_bit_count;
  counter_t   next_err_count;
  counter_t   next_bit_snap;
  counter_t   next_err_snap;
  logic [7:0] next_bit_prescale;
  logic       counting;
  logic       bit_error;

  assign counting  = RATE_BLOCK && ctl_low[1] && count_on;
  assign bit_error = sample_eye ^ sample_cdr;
  always_comb
  begin
    next_bit_count    = bit_count;
    next_err_count    = err_count;
    next_bit_snap     = bit_snap;
    next_err_snap     = err_snap;
    next_bit_prescale = bit_prescale;
    if (counting)
    begin
      next_bit_prescale = bit_prescale + 8'h01;
      if (bit_prescale == 8'(`BITS_PER_INCREMENT - 1))
        next_bit_count = bit_count + 64'h1;
      if (bit_error)
        next_err_count = err_count + 64'h1;
    end
    if (do_snap)
    begin
      next_bit_snap = bit_count;
      next_err_snap = err_count;
    end
    if (do_clear_snap)
    begin
      next_bit_snap = 64'h0;
      next_err_snap = 64'h0;
    end
    if (do_clear_cnt)
    begin
      next_bit_count    = 64'h0;
      next_err_count    = 64'h0;
      next_bit_prescale = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_count        <= 64'h0;
      err_count        <= 64'h0;
      bit_snap         <= 64'h0;
      err_snap         <= 64'h0;
      bit_prescale     <= 8'h00;
      phys_channel     <= 10'h000;
      monitor_on       <= 1'b0;
      phase_step       <= 6'h00;
      height_level     <= 6'h00;
      height_positive  <= 1'b0;
      single_axis_mode <= 1'b0;
      checker_on       <= 1'b0;
    end
    else
    begin
      bit_count        <= next_bit_count;
      err_count        <= next_err_count;
      bit_snap         <= next_bit_snap;
      err_snap         <= next_err_snap;
      bit_prescale     <= next_bit_prescale;
      // identity map; a board-specific table would replace it
      phys_channel     <= channel_select;
      monitor_on       <= ctl_low[0];
      phase_step       <= hphase;
      height_level     <= vheight;
      height_positive  <= mode_pol[`MODE_POL_BIT];
      single_axis_mode <= mode_pol[`MODE_SINGLE_AXIS_BIT];
      checker_on       <= RATE_BLOCK && ctl_low[1];
    end
  end

endmodule

`default_nettype wire
